// *** testbench/cg_osc_model.sv ***
// Resonator model that turns the enabled oscillators into tick pulses.
`timescale 1ns/1ps
module cg_osc_model #(
  parameter int MAIN_DIV = 2, // Clock cycles per main oscillator period.
  parameter int SUB_DIV = 24 // Clock cycles per sub oscillator period.
) (
  input wire logic pclk, // Bench clock.
  input wire logic main_en, // Main oscillator enable.
  input wire logic sub_en, // Sub oscillator enable.
  output logic main_tick, // One pulse per main period.
  output logic sub_tick // One pulse per sub period.
);
  int main_cnt = 0;
  int sub_cnt = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Main runs well above three times the sub rate so mode switches stay legal.
  initial begin
    main_tick = 1'b0;
    sub_tick = 1'b0;
  end
  // A halted resonator gives no ticks at all, so a stuck enable shows as a dead clock.
  always @(posedge pclk) begin
    main_tick <= main_en && main_cnt == 0;
    sub_tick <= sub_en && sub_cnt == 0;
    if (main_en) begin
      main_cnt <= (main_cnt + 1) % MAIN_DIV;
    end
    if (sub_en) begin
      sub_cnt <= (sub_cnt + 1) % SUB_DIV;
    end
  end
endmodule : cg_osc_model

// *** testbench/tb.sv ***
// Self-checking testbench of the clock generation block.
`timescale 1ns/1ps
module tb;
  localparam int MD = 2;
  localparam int SD = 24;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mtick, stick, phi, cpu_held, m_en, s_en, port_mode;
  logic stop_i = 1'b0;
  logic wait_i = 1'b0;
  logic ext_irq = 1'b0;
  logic irq_acc = 1'b0;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Design, oscillator model and clock.
  cg_clock_ctl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_osc_tick(mtick), .sub_osc_tick(stick),
    .stop_instruction(stop_i), .wait_instruction(wait_i), .ext_irq(ext_irq),
    .irq_accepted(irq_acc), .phi(phi), .cpu_held(cpu_held), .main_osc_en(m_en),
    .sub_osc_en(s_en), .sub_osc_port_mode(port_mode));
  cg_osc_model #(.MAIN_DIV(MD), .SUB_DIV(SD)) i_osc (.pclk(pclk), .main_en(m_en),
    .sub_en(s_en), .main_tick(mtick), .sub_tick(stick));
  always #2 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(pready), 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
  endtask : apb
  // Waits for the next rising edge of phi, seen at falling clock edges.
  task automatic rise(inout int n);
    while (phi !== 1'b0 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    while (phi !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
  endtask : rise
  // Measures one phi period after letting a mode change settle.
  task automatic period(output int n);
    int k;
    k = 0;
    rise(k);
    rise(k);
    n = 0;
    rise(n);
  endtask : period
  // Pulses one control input for a cycle: 0 stop, 1 wait, 2 ext interrupt, 3 accepted.
  task automatic pulse(input logic [1:0] sel);
    @(posedge pclk);
    stop_i <= (sel == 2'h0);
    wait_i <= (sel == 2'h1);
    ext_irq <= (sel == 2'h2);
    irq_acc <= (sel == 2'h3);
    @(posedge pclk);
    stop_i <= 1'b0;
    wait_i <= 1'b0;
    ext_irq <= 1'b0;
    irq_acc <= 1'b0;
    @(negedge pclk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, port mode of the sub pins and an unmapped access.
  task automatic t_reset;
    chk(32'(port_mode), 32'h1);
    chk(32'(s_en), 32'h0);
    apb(8'h3b, 1'b0, 8'h00);
    chk(rdat, 32'h48);
    apb(8'h20, 1'b0, 8'h00);
    chk(rdat, 32'hff);
    apb(8'h21, 1'b0, 8'h00);
    chk(rdat, 32'h01);
    apb(8'h11, 1'b0, 8'h00);
    chk({rdat[30:0], rerr}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  // Speed modes and the main stop bit in low-speed mode.
  task automatic t_modes;
    int n;
    period(n);
    chk(32'(n), 32'(8 * MD));
    apb(8'h3b, 1'b1, 8'h08);
    period(n);
    chk(32'(n), 32'(2 * MD));
    apb(8'h3b, 1'b1, 8'h98);
    @(negedge pclk);
    chk({30'h0, s_en, port_mode}, 32'h2);
    period(n);
    chk(32'(n), 32'(2 * SD));
    apb(8'h3b, 1'b1, 8'hb8);
    @(negedge pclk);
    chk(32'(m_en), 32'h0);
    apb(8'h3b, 1'b1, 8'h98);
    @(negedge pclk);
    chk(32'(m_en), 32'h1);
    apb(8'h3b, 1'b1, 8'h48);
    $display("test modes done");
  endtask : t_modes
  // Stop entry, counter preset or keep, and the wake delay after an interrupt.
  task automatic t_stop(input logic keep, input logic [7:0] pr, input logic [7:0] tm);
    int n;
    int exp;
    logic hi;
    hi = 1'b1;
    apb(8'h10, 1'b1, {7'h0, keep});
    if (keep) begin
      apb(8'h20, 1'b1, pr);
      apb(8'h21, 1'b1, tm);
    end
    pulse(2'h0);
    chk({28'h0, cpu_held, phi, m_en, s_en}, 32'hc);
    apb(8'h20, 1'b0, 8'h00);
    chk(rdat, {24'h0, pr});
    apb(8'h21, 1'b0, 8'h00);
    chk(rdat, {24'h0, tm});
    pulse(2'h2);
    n = 1;
    exp = 16 * (pr + 1) * (tm + 1) * MD;
    while (cpu_held === 1'b1 && n < 20000) begin
      hi = hi & (phi === 1'b1);
      @(negedge pclk);
      n++;
    end
    chk(32'(hi), 32'h1);
    tests_run++;
    if (n < exp - 40 || n > exp + 40) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, exp);
    end
    apb(8'h10, 1'b1, 8'h00);
    $display("test stop done");
  endtask : t_stop
  // Wait keeps the main oscillator running and resumes at once on an interrupt.
  task automatic t_wait;
    pulse(2'h1);
    chk({29'h0, cpu_held, phi, m_en}, 32'h7);
    repeat (10) @(negedge pclk);
    chk(32'(phi), 32'h1);
    pulse(2'h3);
    chk(32'(cpu_held), 32'h0);
    $display("test wait done");
  endtask : t_wait
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_modes();
    t_stop(1'b0, 8'hff, 8'h01);
    t_stop(1'b1, 8'h03, 8'h01);
    t_wait();
    stop_test();
  end
  // Watchdog sized well above the longest wake delay.
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
endmodule : tb

// *** verilog/cg_clock_ctl.sv ***
// Clock generation, speed modes and stop/wait oscillation control with an APB register file.
//
// Functional notes
// - Only main oscillator runs until sub enabled.
// - Middle-speed: main divided by eight, reset default.
// - High-speed: main divided by two.
// - Low-speed: sub divided by two.
// - Main-stop bit halts main in low-speed.
// - Stop freezes clock high, halts both oscillators.
// - Stop loads prescaler FF, timer 01.
// - Keep bit set: stop leaves counters untouched.
// - Prescaler counts stop-time source, clocks timer.
// - External interrupt wakes; clock held until underflow.
// - Wait freezes clock, oscillators keep running.
// - Wait release resumes at once.
// - Wake counters count main divided by sixteen.
// - Latch value n divides by n plus one.
// - Reset values: mode 48, prescaler FF, timer 01.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module cg_clock_ctl (
  input wire logic pclk, // APB and system clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic main_osc_tick, // One pulse per main oscillator period.
  input wire logic sub_osc_tick, // One pulse per sub oscillator period.
  input wire logic stop_instruction, // CPU executes the stop instruction.
  input wire logic wait_instruction, // CPU executes the wait instruction.
  input wire logic ext_irq, // External interrupt that may end stop.
  input wire logic irq_accepted, // Any accepted interrupt, ends wait.
  output logic phi, // Internal system clock level.
  output logic cpu_held, // High while the CPU clock is withheld.
  output logic main_osc_en, // Main oscillator enable.
  output logic sub_osc_en, // Sub oscillator enable.
  output logic sub_osc_port_mode // Sub oscillator pins act as general ports.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file over APB.

  logic [7:0] cpu_mode_register;
  logic [7:0] stop_ctl;
  logic [7:0] next_cpu_mode_register;
  logic [7:0] next_stop_ctl;
  logic [31:0] next_prdata;
  logic [7:0] idx;
  logic in_range;
  logic hit_mode;
  logic hit_stop;
  logic hit_pre;
  logic hit_tmr;
  logic mapped;
  logic wr_acc;
  logic [7:0] wake_prescaler;
  logic [7:0] wake_timer;
  logic [1:0] speed_mode;

  // Decode the word index; higher and unaligned bits must be zero.
  always_comb begin
    idx = paddr[9:2];
    in_range = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    hit_mode = in_range && (idx == cg_pkg::IDX_CPU_MODE);
    hit_stop = in_range && (idx == cg_pkg::IDX_STOP_CTL);
    hit_pre = in_range && (idx == cg_pkg::IDX_PRE);
    hit_tmr = in_range && (idx == cg_pkg::IDX_TMR);
    mapped = hit_mode || hit_stop || hit_pre || hit_tmr;
    wr_acc = psel && penable && pwrite && mapped;
    pready = 1'b1;
    pslverr = psel && penable && !mapped;
  end

  // Next register values; read data is captured in the setup cycle.
  always_comb begin
    next_cpu_mode_register = cpu_mode_register;
    next_stop_ctl = stop_ctl;
    next_prdata = prdata;
    if (wr_acc && hit_mode) begin
      next_cpu_mode_register = pwdata[7:0];
    end
    if (wr_acc && hit_stop) begin
      next_stop_ctl = pwdata[7:0];
    end
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (hit_mode) begin
        next_prdata = {24'h00_0000, cpu_mode_register};
      end else if (hit_stop) begin
        next_prdata = {24'h00_0000, stop_ctl};
      end else if (hit_pre) begin
        next_prdata = {24'h00_0000, wake_prescaler};
      end else if (hit_tmr) begin
        next_prdata = {24'h00_0000, wake_timer};
      end
    end
  end

  // Register the software-visible state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mode_register <= cg_pkg::CPU_MODE_RST;
      stop_ctl <= cg_pkg::STOP_CTL_RST;
      prdata <= 32'h0000_0000;
    end else begin
      cpu_mode_register <= next_cpu_mode_register;
      stop_ctl <= next_stop_ctl;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stop and wait sequencing.

  cg_pkg::cg_state_t state;
  cg_pkg::cg_state_t next_state;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic wake_tick;
  logic preset;
  logic underflow;
  logic main_stop_req;
  logic phi_freeze;

  // Stop and wait are honoured only while running; stray wake events elsewhere are ignored.
  always_comb begin
    next_state = state;
    case (state)
      cg_pkg::ST_RUN: begin
        if (stop_instruction) begin
          next_state = cg_pkg::ST_STOP;
        end else if (wait_instruction) begin
          next_state = cg_pkg::ST_WAIT;
        end
      end
      cg_pkg::ST_STOP: begin
        if (ext_irq) begin
          next_state = cg_pkg::ST_WAKE;
        end
      end
      cg_pkg::ST_WAKE: begin
        if (underflow) begin
          next_state = cg_pkg::ST_RUN;
        end
      end
      cg_pkg::ST_WAIT: begin
        if (irq_accepted) begin
          next_state = cg_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = cg_pkg::ST_RUN;
      end
    endcase
  end

  // Divide the main oscillator by sixteen while waking, as the wake count source.
  always_comb begin
    next_div_cnt = 4'h0;
    wake_tick = 1'b0;
    if (state == cg_pkg::ST_WAKE) begin
      next_div_cnt = div_cnt;
      if (main_osc_tick) begin
        next_div_cnt = div_cnt + 4'h1;
        wake_tick = (div_cnt == cg_pkg::WAKE_DIV_LAST);
      end
    end
  end

  // Register the sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cg_pkg::ST_RUN;
      div_cnt <= 4'h0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
    end
  end

  // Stop-entry preset unless software chose to supply its own delay.
  assign preset = (state == cg_pkg::ST_RUN) && stop_instruction
                  && !stop_ctl[cg_pkg::BIT_STAB_KEEP];

  cg_wake_cnt u_wake (
    .clk(pclk),
    .rst_n(presetn),
    .wr_pre(wr_acc && hit_pre),
    .wr_tmr(wr_acc && hit_tmr),
    .wdata(pwdata[7:0]),
    .preset(preset),
    .cnt_tick(wake_tick),
    .pre(wake_prescaler),
    .tmr(wake_timer),
    .underflow(underflow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator enables and internal clock.

  assign speed_mode = cpu_mode_register[cg_pkg::MODE_MSB:cg_pkg::MODE_LSB];
  assign main_stop_req = cpu_mode_register[cg_pkg::BIT_MAIN_STOP]
                         && (speed_mode == cg_pkg::MODE_LOW);

  // Both oscillators halt in stop; the main one also on request in low-speed mode.
  always_comb begin
    main_osc_en = (state != cg_pkg::ST_STOP) && !main_stop_req;
    sub_osc_en = (state != cg_pkg::ST_STOP)
                 && cpu_mode_register[cg_pkg::BIT_SUB_EN];
    sub_osc_port_mode = !cpu_mode_register[cg_pkg::BIT_SUB_EN];
    cpu_held = (state != cg_pkg::ST_RUN);
    // Freezing on the instruction itself makes phi high in the first held cycle.
    phi_freeze = cpu_held
                 || ((state == cg_pkg::ST_RUN) && (stop_instruction || wait_instruction));
  end

  cg_phi_gen u_phi (
    .clk(pclk),
    .rst_n(presetn),
    .main_tick(main_osc_tick),
    .sub_tick(sub_osc_tick),
    .mode(speed_mode),
    .freeze(phi_freeze),
    .phi(phi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_stop_frozen;
    @(posedge pclk) disable iff (!presetn)
    (state == cg_pkg::ST_STOP) |-> (phi && !main_osc_en && !sub_osc_en);
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("stop not frozen");

  property p_stop_load;
    @(posedge pclk) disable iff (!presetn)
    ((state == cg_pkg::ST_RUN) && stop_instruction && !stop_ctl[0])
      |=> (wake_prescaler == 8'hff) && (wake_timer == 8'h01);
  endproperty
  a_stop_load: assert property (p_stop_load) else $error("stop preset missing");

  property p_stop_keep;
    @(posedge pclk) disable iff (!presetn)
    ((state == cg_pkg::ST_RUN) && stop_instruction && stop_ctl[0] && !wr_acc)
      |=> $stable(wake_prescaler) && $stable(wake_timer);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("counters changed on stop");

  property p_wake_start;
    @(posedge pclk) disable iff (!presetn)
    ((state == cg_pkg::ST_STOP) && ext_irq) |=> (state == cg_pkg::ST_WAKE) && phi;
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("no wake on interrupt");

  property p_wake_held;
    @(posedge pclk) disable iff (!presetn)
    (state == cg_pkg::ST_WAKE) && !underflow |=> (state == cg_pkg::ST_WAKE) && phi;
  endproperty
  a_wake_held: assert property (p_wake_held) else $error("clock released early");

  property p_wake_end;
    @(posedge pclk) disable iff (!presetn)
    ((state == cg_pkg::ST_WAKE) && underflow) |=> (state == cg_pkg::ST_RUN);
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("no release on underflow");

  property p_wake_div;
    @(posedge pclk) disable iff (!presetn)
    wake_tick |-> (state == cg_pkg::ST_WAKE) && main_osc_tick && (div_cnt == 4'hf);
  endproperty
  a_wake_div: assert property (p_wake_div) else $error("wake source not main/16");

  property p_wait_hold;
    @(posedge pclk) disable iff (!presetn)
    (state == cg_pkg::ST_WAIT) |-> phi && (main_osc_en || main_stop_req);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait state wrong");

  property p_wait_release;
    @(posedge pclk) disable iff (!presetn)
    ((state == cg_pkg::ST_WAIT) && irq_accepted) |=> (state == cg_pkg::ST_RUN);
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released");

  property p_main_stop;
    @(posedge pclk) disable iff (!presetn)
    (cpu_mode_register[5] && (speed_mode == 2'h2)) |-> !main_osc_en;
  endproperty
  a_main_stop: assert property (p_main_stop) else $error("main clock not halted");

endmodule : cg_clock_ctl

// *** verilog/cg_phi_gen.sv ***
// Internal system clock divider with whole-half-period source switching.
`timescale 1ns/1ps
module cg_phi_gen (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic main_tick, // One pulse per main oscillator period.
  input wire logic sub_tick, // One pulse per sub oscillator period.
  input wire logic [1:0] mode, // Requested speed mode.
  input wire logic freeze, // Hold the internal clock high.
  output logic phi // Internal system clock level.
);

  logic [2:0] cnt;
  logic [1:0] act_mode;
  logic next_phi;
  logic [2:0] next_cnt;
  logic [1:0] next_act_mode;
  logic src;
  logic [2:0] half_last;

  // Outside freeze, a new mode is only taken when a high half starts; freeze takes it at once and can cut a low half short.
  always_comb begin
    next_phi = phi;
    next_cnt = cnt;
    next_act_mode = act_mode;
    src = (act_mode == cg_pkg::MODE_LOW) ? sub_tick : main_tick;
    half_last = (act_mode == cg_pkg::MODE_MIDDLE) ? cg_pkg::HALF_LAST_MIDDLE
                                                  : cg_pkg::HALF_LAST_FAST;
    if (freeze) begin
      next_phi = 1'b1;
      next_cnt = 3'h0;
      next_act_mode = mode;
    end else if (src) begin
      if (cnt == half_last) begin
        next_cnt = 3'h0;
        next_phi = ~phi;
        if (!phi) begin
          next_act_mode = mode;
        end
      end else begin
        next_cnt = cnt + 3'h1;
      end
    end
  end

  // Register the divider state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phi <= 1'b1;
      cnt <= 3'h0;
      act_mode <= cg_pkg::MODE_MIDDLE;
    end else begin
      phi <= next_phi;
      cnt <= next_cnt;
      act_mode <= next_act_mode;
    end
  end

endmodule : cg_phi_gen

// *** verilog/cg_pkg.sv ***
// Constants, register indices and state encodings of the clock generation block.
package cg_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] IDX_STOP_CTL = 8'h10;
  localparam logic [7:0] IDX_PRE = 8'h20;
  localparam logic [7:0] IDX_TMR = 8'h21;
  localparam logic [7:0] IDX_CPU_MODE = 8'h3b;

  // Reset values.
  localparam logic [7:0] CPU_MODE_RST = 8'h48;
  localparam logic [7:0] STOP_CTL_RST = 8'h00;
  localparam logic [7:0] PRE_RST = 8'hff;
  localparam logic [7:0] TMR_RST = 8'h01;

  // Values forced into the wake counters by a stop instruction.
  localparam logic [7:0] PRE_STOP_LOAD = 8'hff;
  localparam logic [7:0] TMR_STOP_LOAD = 8'h01;

  // Field positions.
  localparam int BIT_STAB_KEEP = 0;
  localparam int BIT_SUB_EN = 4;
  localparam int BIT_MAIN_STOP = 5;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;

  // Clock speed modes held in the top two bits of the CPU mode register.
  localparam logic [1:0] MODE_HIGH = 2'h0;
  localparam logic [1:0] MODE_MIDDLE = 2'h1;
  localparam logic [1:0] MODE_LOW = 2'h2;

  // Last count of a half period, in source ticks (middle: 4 ticks per half of divide by 8).
  localparam logic [2:0] HALF_LAST_MIDDLE = 3'h3;
  localparam logic [2:0] HALF_LAST_FAST = 3'h0;

  // Last count of the divide-by-16 wake count source.
  localparam logic [3:0] WAKE_DIV_LAST = 4'hf;

  // Oscillation control states.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_WAKE = 2'b10,
    ST_WAIT = 2'b11
  } cg_state_t;

endpackage : cg_pkg

// *** verilog/cg_wake_cnt.sv ***
// Wake prescaler and wake timer with reload latches.
`timescale 1ns/1ps
module cg_wake_cnt (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic wr_pre, // Software write to the prescaler.
  input wire logic wr_tmr, // Software write to the timer.
  input wire logic [7:0] wdata, // Write data.
  input wire logic preset, // Force the stop-entry values.
  input wire logic cnt_tick, // Count source pulse.
  output logic [7:0] pre, // Prescaler count.
  output logic [7:0] tmr, // Timer count.
  output logic underflow // Timer underflow pulse.
);

  logic [7:0] pre_latch;
  logic [7:0] tmr_latch;
  logic [7:0] next_pre;
  logic [7:0] next_tmr;
  logic [7:0] next_pre_latch;
  logic [7:0] next_tmr_latch;
  logic pre_out;

  // Each stage divides by its latch value plus one; the prescaler output clocks the timer.
  always_comb begin
    next_pre = pre;
    next_tmr = tmr;
    next_pre_latch = pre_latch;
    next_tmr_latch = tmr_latch;
    pre_out = 1'b0;
    underflow = 1'b0;
    if (preset) begin
      next_pre = cg_pkg::PRE_STOP_LOAD;
      next_tmr = cg_pkg::TMR_STOP_LOAD;
      next_pre_latch = cg_pkg::PRE_STOP_LOAD;
      next_tmr_latch = cg_pkg::TMR_STOP_LOAD;
    end else if (cnt_tick) begin
      if (pre == 8'h00) begin
        next_pre = pre_latch;
        pre_out = 1'b1;
      end else begin
        next_pre = pre - 8'h01;
      end
      if (pre_out) begin
        if (tmr == 8'h00) begin
          next_tmr = tmr_latch;
          underflow = 1'b1;
        end else begin
          next_tmr = tmr - 8'h01;
        end
      end
    end
    if (wr_pre) begin
      next_pre = wdata;
      next_pre_latch = wdata;
    end
    if (wr_tmr) begin
      next_tmr = wdata;
      next_tmr_latch = wdata;
    end
  end

  // Register counters and latches.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= cg_pkg::PRE_RST;
      tmr <= cg_pkg::TMR_RST;
      pre_latch <= cg_pkg::PRE_RST;
      tmr_latch <= cg_pkg::TMR_RST;
    end else begin
      pre <= next_pre;
      tmr <= next_tmr;
      pre_latch <= next_pre_latch;
      tmr_latch <= next_tmr_latch;
    end
  end

endmodule : cg_wake_cnt
